// [include/cfm_params.svh]
// offsets, field positions, reset values of the charger fault mask bank
// What this block does
// - bit 7 of first mask gates input overvoltage; 1 masks; reset 0
// - bit 5 of first mask gates battery overcurrent; 1 masks; reset 0
// - bit 4 of first mask gates battery undervoltage; 1 masks; reset 0
// - bits 3..0 of first mask gate cold, cool, warm, hot; reset 0
// - bit 6 of first mask is spare read/write, reset 0, no effect
// - bit 7 of adc mask gates conversion ready; reset 0, enabled
// - bits 6..4 of adc mask gate comparators one..three; reset 1
// - bit 0 of adc mask gates thermistor open; reset 1; whole 0x71
// - bits 3..1 of adc mask are spare read/write, reset 000
// - bit 6 of timer mask gates watchdog expiry; reset 0
// - bit 5 of timer mask gates charge safety timer expiry; reset 0
// - bit 4 of timer mask gates regulator overcurrent; reset 0
// - bit 3 of timer mask gates limit resistor open; reset 0
// - bits 2 and 1 of timer mask gate button wake one, two
// - bit 0 of timer mask gates reset warning; bit 7 spare, reset 0
// - each flag latches on its event and clears when its register is read
// - comparator flags set when measurement passes threshold in chosen way
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH
`define CFM_FLAG_BT_OFS 8'h04
`define CFM_FLAG_ADC_OFS 8'h05
`define CFM_FLAG_TMR_OFS 8'h06
`define CFM_GATE_BT_OFS 8'h08
`define CFM_GATE_ADC_OFS 8'h09
`define CFM_GATE_TMR_OFS 8'h0A
`define CFM_GATE_BT_RST 8'h00
`define CFM_GATE_ADC_RST 8'h71
`define CFM_GATE_TMR_RST 8'h00
`define CFM_FLAG_RST 8'h00
// bits that name a real interrupt source in each register
`define CFM_SRC_BT 8'hBF
`define CFM_SRC_ADC 8'hF1
`define CFM_SRC_TMR 8'h7F
// field positions
`define CFM_BIT_OVP 7
`define CFM_BIT_BAT_OC 5
`define CFM_BIT_BAT_UV 4
`define CFM_BIT_ADC_RDY 7
`define CFM_BIT_CMP1 6
`define CFM_BIT_CMP2 5
`define CFM_BIT_CMP3 4
`define CFM_BIT_TS_OPEN 0
`define CFM_BIT_WDOG 6
`define CFM_BIT_CHG_TMR 5
`define CFM_BIT_LDO_OC 4
`define CFM_BIT_RLIM 3
`define CFM_BIT_WAKE1 2
`define CFM_BIT_WAKE2 1
`define CFM_BIT_RST_WARN 0
`endif

// [include/cfm_pkg.sv]
// types of the charger fault mask bank
package cfm_pkg;
  typedef struct packed {
    logic [7:0] gate_bt;
    logic [7:0] gate_adc;
    logic [7:0] gate_tmr;
    logic [7:0] flag_bt;
    logic [7:0] flag_adc;
    logic [7:0] flag_tmr;
    logic [7:0] rdata;
    logic irq;
  } cfm_state_t;
endpackage

// [test/cfm_host_model.sv]
// host side of the register port, one strobed byte at a time
module cfm_host_model (
  // clock
  input wire logic ref_clk,
  // register port toward the mask bank
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one access held for one edge, then address and data scrambled
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // write then read back on the very next edge, no idle cycle
  task automatic write_read(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// [test/charger_fault_irq_mask_bank_tb.sv]
// self-checking bench of the charger fault mask bank
module charger_fault_irq_mask_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin exp_v = (b); check_count++; \
  if ((a) !== exp_v) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), exp_v); end end

  logic ref_clk, rst_n, reg_wr, reg_rd, irq_pulse, rd_seen, ev_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_v, m;
  logic [23:0] ev_v;
  logic [23:0] src = 24'hBF817F;
  logic [15:0] res, r;
  logic [15:0] thr [3];
  logic [2:0] above;
  logic [7:0] rq [$];
  logic iq [$];
  int failures, check_count, k, b;

  cfm_irq_mask_bank i_cfm_irq_mask_bank (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_input_overvoltage(ev_v[23]), .ev_battery_overcurrent(ev_v[21]),
    .ev_battery_undervoltage(ev_v[20]), .ev_ts_region(ev_v[19:16]),
    .ev_adc_ready(ev_v[15]), .ev_ts_open(ev_v[8]), .adc_result(res),
    .comp_threshold_1(thr[0]), .comp_threshold_2(thr[1]),
    .comp_threshold_3(thr[2]), .comp_above(above),
    .ev_watchdog(ev_v[6]), .ev_charge_timer(ev_v[5]),
    .ev_regulator_oc(ev_v[4]), .ev_limit_resistor_open(ev_v[3]),
    .ev_wake_first(ev_v[2]), .ev_wake_second(ev_v[1]),
    .ev_reset_warn(ev_v[0]), .irq_pulse(irq_pulse));

  cfm_host_model i_cfm_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // result watcher: read data and interrupt against oldest note
  always @(posedge ref_clk) begin
    if (rst_n) begin
      if (rd_seen) `CHK(reg_rdata, rq.pop_front())
      `CHK(irq_pulse, ev_seen ? iq.pop_front() : 1'b0)
    end
    rd_seen <= reg_rd;
    ev_seen <= |ev_v;
  end

  // read with noted expectation
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    i_cfm_host_model.access(1'b0, a, 8'h00);
  endtask

  // event held two edges: first may interrupt, second never
  task automatic fire(input int i, input logic e);
    @(posedge ref_clk);
    ev_v <= 24'h000001 << i;
    iq.push_back(e);
    iq.push_back(1'b0);
    @(posedge ref_clk);
    @(posedge ref_clk);
    ev_v <= 24'h000000;
  endtask

  // count summary and verdict
  task automatic results();
    if (rq.size() != 0 || iq.size() != 0)
      failures++;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    results();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    ev_v = 24'h000000;
    res = 16'h0000;
    foreach (thr[n]) thr[n] = 16'h0000;
    above = 3'h0;
    rd_seen = 1'b0;
    ev_seen = 1'b0;
    failures = 0;
    check_count = 0;
    void'($urandom(32'h24A7));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, refused write and unmapped read
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h71);
    rd(8'h0A, 8'h00);
    i_cfm_host_model.access(1'b1, 8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    rd(8'h0B, 8'h00);
    // write and read back on adjacent edges, spare bit set
    m = 8'($urandom) | 8'h40;
    rq.push_back(m);
    i_cfm_host_model.write_read(8'h08, m);
    // every direct source, unmasked then masked, other gates random
    for (int i = 0; i < 24; i++) begin
      for (int j = 0; j < 2 && src[i]; j++) begin
        k = 2 - i / 8;
        b = i % 8;
        m = 8'($urandom);
        m[b] = j[0];
        i_cfm_host_model.access(1'b1, 8'(8 + k), m);
        rd(8'(8 + k), m);
        fire(i, ~m[b]);
        rd(8'(4 + k), 8'(1 << b));
        rd(8'(4 + k), 8'h00);
      end
    end
    // comparators: above, boundary, below
    i_cfm_host_model.access(1'b1, 8'h09, 8'h00);
    r = 16'($urandom % 32'hFFFD) + 16'h0001;
    @(posedge ref_clk);
    res <= r;
    thr[0] <= r - 16'h0001;
    thr[1] <= r;
    thr[2] <= r + 16'h0001;
    above <= 3'b011;
    fire(15, 1'b1);
    rd(8'h05, 8'hD0);
    // reset in mid-run restores gate
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h09, 8'h71);
    // every adc source masked, then only the ready source masked
    i_cfm_host_model.access(1'b1, 8'h09, 8'hF1);
    fire(15, 1'b0);
    rd(8'h05, 8'hD0);
    i_cfm_host_model.access(1'b1, 8'h09, 8'h80);
    fire(15, 1'b1);
    rd(8'h05, 8'hD0);
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule

// [verilog/cfm_irq_mask_bank.sv]
// fault flags, interrupt masks and interrupt pulse of the charger
`include "cfm_params.svh"
module cfm_irq_mask_bank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port from the serial interface logic
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // battery and thermistor events, one-cycle pulses
  input wire logic ev_input_overvoltage,
  input wire logic ev_battery_overcurrent,
  input wire logic ev_battery_undervoltage,
  input wire logic [3:0] ev_ts_region,
  // adc events and comparator setup
  input wire logic ev_adc_ready,
  input wire logic ev_ts_open,
  input wire logic [15:0] adc_result,
  input wire logic [15:0] comp_threshold_1,
  input wire logic [15:0] comp_threshold_2,
  input wire logic [15:0] comp_threshold_3,
  input wire logic [2:0] comp_above,
  // timer and regulator events
  input wire logic ev_watchdog,
  input wire logic ev_charge_timer,
  input wire logic ev_regulator_oc,
  input wire logic ev_limit_resistor_open,
  input wire logic ev_wake_first,
  input wire logic ev_wake_second,
  input wire logic ev_reset_warn,
  // interrupt to the host
  output logic irq_pulse
);

  localparam cfm_pkg::cfm_state_t RST_ST = '{
    gate_bt: `CFM_GATE_BT_RST,
    gate_adc: `CFM_GATE_ADC_RST,
    gate_tmr: `CFM_GATE_TMR_RST,
    flag_bt: `CFM_FLAG_RST,
    flag_adc: `CFM_FLAG_RST,
    flag_tmr: `CFM_FLAG_RST,
    rdata: 8'h00,
    irq: 1'b0
  };

  cfm_pkg::cfm_state_t st_r;
  cfm_pkg::cfm_state_t st_nxt;
  logic [7:0] set_bt;
  logic [7:0] set_adc;
  logic [7:0] set_tmr;
  logic [7:0] new_bt;
  logic [7:0] new_adc;
  logic [7:0] new_tmr;
  logic rd_bt;
  logic rd_adc;
  logic rd_tmr;

  // comparator test in the direction chosen for it
  function automatic logic cmp_hit(input logic [15:0] val,
                                   input logic [15:0] thr,
                                   input logic above);
    cmp_hit = above ? (val > thr) : (val < thr);
  endfunction

  // newly set flags: was clear, or being cleared this very cycle
  function automatic logic [7:0] fresh(input logic [7:0] set,
                                       input logic [7:0] flag,
                                       input logic clr);
    fresh = set & (~flag | {8{clr}});
  endfunction

  // event vectors laid out as in the flag registers
  always_comb begin
    set_bt = 8'h00;
    set_bt[`CFM_BIT_OVP] = ev_input_overvoltage;
    set_bt[`CFM_BIT_BAT_OC] = ev_battery_overcurrent;
    set_bt[`CFM_BIT_BAT_UV] = ev_battery_undervoltage;
    set_bt[3:0] = ev_ts_region; // cold, cool, warm, hot
    set_adc = 8'h00;
    set_adc[`CFM_BIT_ADC_RDY] = ev_adc_ready;
    set_adc[`CFM_BIT_CMP1] = ev_adc_ready &&
      cmp_hit(adc_result, comp_threshold_1, comp_above[0]);
    set_adc[`CFM_BIT_CMP2] = ev_adc_ready &&
      cmp_hit(adc_result, comp_threshold_2, comp_above[1]);
    set_adc[`CFM_BIT_CMP3] = ev_adc_ready &&
      cmp_hit(adc_result, comp_threshold_3, comp_above[2]);
    set_adc[`CFM_BIT_TS_OPEN] = ev_ts_open;
    set_tmr = 8'h00;
    set_tmr[`CFM_BIT_WDOG] = ev_watchdog;
    set_tmr[`CFM_BIT_CHG_TMR] = ev_charge_timer;
    set_tmr[`CFM_BIT_LDO_OC] = ev_regulator_oc;
    set_tmr[`CFM_BIT_RLIM] = ev_limit_resistor_open;
    set_tmr[`CFM_BIT_WAKE1] = ev_wake_first;
    set_tmr[`CFM_BIT_WAKE2] = ev_wake_second;
    set_tmr[`CFM_BIT_RST_WARN] = ev_reset_warn;
  end

  // read strobes of the clear-on-read flag registers
  assign rd_bt = reg_rd && (reg_addr == `CFM_FLAG_BT_OFS);
  assign rd_adc = reg_rd && (reg_addr == `CFM_FLAG_ADC_OFS);
  assign rd_tmr = reg_rd && (reg_addr == `CFM_FLAG_TMR_OFS);

  // fresh flags that also pass their gate
  assign new_bt = fresh(set_bt, st_r.flag_bt, rd_bt) &
                  ~st_r.gate_bt & `CFM_SRC_BT;
  assign new_adc = fresh(set_adc, st_r.flag_adc, rd_adc) &
                   ~st_r.gate_adc & `CFM_SRC_ADC;
  assign new_tmr = fresh(set_tmr, st_r.flag_tmr, rd_tmr) &
                   ~st_r.gate_tmr & `CFM_SRC_TMR;

  // next state: writes, flags, read data, interrupt
  always_comb begin
    st_nxt = st_r;
    if (reg_wr) begin
      case (reg_addr)
        `CFM_GATE_BT_OFS: st_nxt.gate_bt = reg_wdata;
        `CFM_GATE_ADC_OFS: st_nxt.gate_adc = reg_wdata;
        `CFM_GATE_TMR_OFS: st_nxt.gate_tmr = reg_wdata;
        default: st_nxt.gate_bt = st_r.gate_bt;
      endcase
    end
    // set wins over the clear of a read
    st_nxt.flag_bt = (st_r.flag_bt & ~{8{rd_bt}}) | set_bt;
    st_nxt.flag_adc = (st_r.flag_adc & ~{8{rd_adc}}) | set_adc;
    st_nxt.flag_tmr = (st_r.flag_tmr & ~{8{rd_tmr}}) | set_tmr;
    if (reg_rd) begin
      case (reg_addr)
        `CFM_FLAG_BT_OFS: st_nxt.rdata = st_r.flag_bt;
        `CFM_FLAG_ADC_OFS: st_nxt.rdata = st_r.flag_adc;
        `CFM_FLAG_TMR_OFS: st_nxt.rdata = st_r.flag_tmr;
        `CFM_GATE_BT_OFS: st_nxt.rdata = st_r.gate_bt;
        `CFM_GATE_ADC_OFS: st_nxt.rdata = st_r.gate_adc;
        `CFM_GATE_TMR_OFS: st_nxt.rdata = st_r.gate_tmr;
        default: st_nxt.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    st_nxt.irq = |{new_bt, new_adc, new_tmr};
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq_pulse = st_r.irq;

  // unmasked overvoltage on a clear flag pulses the interrupt
  property p_ovp_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_input_overvoltage && !st_r.flag_bt[7] && !st_r.gate_bt[7])
      |=> irq_pulse && st_r.flag_bt[7];
  endproperty
  a_ovp_irq: assert property (p_ovp_irq)
    else $error("unmasked overvoltage gave no interrupt");

  // an interrupt always has an unmasked fresh cause
  property p_irq_cause;
    @(posedge ref_clk) disable iff (!rst_n)
      irq_pulse |-> $past(|{new_bt, new_adc, new_tmr});
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without unmasked cause");

  // a flag holds until its register is read
  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_battery_overcurrent ##1 !rd_bt[*2]) |=> st_r.flag_bt[5];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overcurrent flag lost before read");

  // reading a flag register with no events clears it, returns old value
  property p_clear_on_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_tmr && set_tmr == 8'h00)
      |=> st_r.flag_tmr == 8'h00 && reg_rdata == $past(st_r.flag_tmr);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("timer flags not cleared on read");

  // whole first mask register, spare bit included, reads back
  property p_gate_bt_rw;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `CFM_GATE_BT_OFS)
      ##1 (reg_rd && reg_addr == `CFM_GATE_BT_OFS && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_gate_bt_rw: assert property (p_gate_bt_rw)
    else $error("first mask register readback wrong");

  // spare adc mask field stores what was written
  property p_gate_adc_spare;
    @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `CFM_GATE_ADC_OFS)
      |=> st_r.gate_adc[3:1] == $past(reg_wdata[3:1]);
  endproperty
  a_gate_adc_spare: assert property (p_gate_adc_spare)
    else $error("adc mask spare field not stored");

  // comparator one alarm follows the above setting
  property p_cmp1;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_adc_ready && comp_above[0] &&
       adc_result > comp_threshold_1) |=> st_r.flag_adc[6];
  endproperty
  a_cmp1: assert property (p_cmp1)
    else $error("comparator one alarm missed");

  // masked watchdog alone latches but raises nothing
  property p_wdog_masked;
    @(posedge ref_clk) disable iff (!rst_n)
      (set_tmr == 8'h40 && st_r.gate_tmr[6] &&
       set_bt == 8'h00 && set_adc == 8'h00)
      |=> !irq_pulse && st_r.flag_tmr[6];
  endproperty
  a_wdog_masked: assert property (p_wdog_masked)
    else $error("masked watchdog raised interrupt");

  // comparator alarms gated by default after reset
  property p_adc_gate_rst;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> st_r.gate_adc == `CFM_GATE_ADC_RST;
  endproperty
  a_adc_gate_rst: assert property (p_adc_gate_rst)
    else $error("adc mask reset value wrong");

  // unmasked cold region entry pulses the interrupt
  property p_ts_cold_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_ts_region[3] && !st_r.flag_bt[3] && !st_r.gate_bt[3])
      |=> irq_pulse && st_r.flag_bt[3];
  endproperty
  a_ts_cold_irq: assert property (p_ts_cold_irq)
    else $error("unmasked cold region gave no interrupt");

  // masked undervoltage alone latches but raises nothing
  property p_bat_uv_masked;
    @(posedge ref_clk) disable iff (!rst_n)
      (set_bt == 8'h10 && st_r.gate_bt[4] &&
       set_adc == 8'h00 && set_tmr == 8'h00)
      |=> !irq_pulse && st_r.flag_bt[4];
  endproperty
  a_bat_uv_masked: assert property (p_bat_uv_masked)
    else $error("masked undervoltage raised interrupt");

  // unmasked conversion ready pulses the interrupt
  property p_adc_rdy_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_adc_ready && !st_r.flag_adc[7] && !st_r.gate_adc[7])
      |=> irq_pulse && st_r.flag_adc[7];
  endproperty
  a_adc_rdy_irq: assert property (p_adc_rdy_irq)
    else $error("unmasked conversion ready gave no interrupt");

  // comparator alarms under a set gate raise nothing
  property p_cmp_masked;
    @(posedge ref_clk) disable iff (!rst_n)
      (set_adc[6:4] != 3'h0 && st_r.gate_adc[7:4] == 4'hF &&
       !set_adc[0] && set_bt == 8'h00 && set_tmr == 8'h00)
      |=> !irq_pulse;
  endproperty
  a_cmp_masked: assert property (p_cmp_masked)
    else $error("masked comparator alarm raised interrupt");

  // a result equal to threshold two never alarms
  property p_cmp2_equal;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_adc_ready && adc_result == comp_threshold_2 &&
       !st_r.flag_adc[5]) |=> !st_r.flag_adc[5];
  endproperty
  a_cmp2_equal: assert property (p_cmp2_equal)
    else $error("comparator two alarmed on equal value");

  // comparator three alarms below its threshold when so chosen
  property p_cmp3_below;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_adc_ready && !comp_above[2] &&
       adc_result < comp_threshold_3) |=> st_r.flag_adc[4];
  endproperty
  a_cmp3_below: assert property (p_cmp3_below)
    else $error("comparator three alarm missed");

  // unmasked charge timer expiry pulses the interrupt
  property p_chg_tmr_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (ev_charge_timer && !st_r.flag_tmr[5] && !st_r.gate_tmr[5])
      |=> irq_pulse && st_r.flag_tmr[5];
  endproperty
  a_chg_tmr_irq: assert property (p_chg_tmr_irq)
    else $error("unmasked charge timer gave no interrupt");

  // an event on a flag already set, with its register not read that cycle, does not pulse again
  property p_no_repulse;
    @(posedge ref_clk) disable iff (!rst_n)
      (set_tmr == 8'h40 && st_r.flag_tmr[6] && !rd_tmr &&
       set_bt == 8'h00 && set_adc == 8'h00) |=> !irq_pulse;
  endproperty
  a_no_repulse: assert property (p_no_repulse)
    else $error("set watchdog flag pulsed again");

  // other mask registers come out of reset cleared
  property p_gate_rst;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> st_r.gate_bt == `CFM_GATE_BT_RST &&
        st_r.gate_tmr == `CFM_GATE_TMR_RST;
  endproperty
  a_gate_rst: assert property (p_gate_rst)
    else $error("mask reset value wrong");

endmodule
